// *** verilog/uc_top.sv ***
// Summary of operation
// - Control bit 2 turns unified cache on
// - Control bit 3 enables write buffer
// - Control bit 4 selects 32-bit program space
// - Control bit 5 selects 32-bit data space
// - Control bit 6 selects late abort timing
// - Control bit 7 selects big-endian
// - Control bit 8 feeds permission checking
// - Table base keeps bits 31 to 14
// - Sixteen two-bit domain access fields held
// - Register 4 access does nothing, never used
// - Status read gives last data fault
// - Register 5 write flushes whole TLB
// - Register 6 read gives fault address
// - Register 6 write purges matching TLB entry
// - Register 7 write invalidates all lines
// - Registers 8 to 15 trap undefined
// - 256 lines, 16 bytes, 64-way, virtual
// - Reset disables the cache
// - Cacheable read hits fast, misses fill line
// - Uncacheable read bypasses cache entirely
// - Updateable write goes out, updates hits
// - Non-updateable write leaves cache untouched
// - Reset clears every control bit
// - User mode transfers trap undefined
`timescale 1ns/1ps
module uc_top
    import uc_pkg::*;
#(
    // Identification value is arbitrary
    parameter logic [DW-1:0] ID_CODE = 32'h0000_0000
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_cp_valid,
    input  wire logic             i_cp_write,
    input  wire logic             i_cp_priv,
    input  wire logic [3:0]       i_cp_reg,
    input  wire logic [DW-1:0]    i_cp_wdata,
    output logic                  o_cp_done,
    output logic                  o_cp_undef,
    output logic      [DW-1:0]    o_cp_rdata,
    output uc_ctrl_s              o_ctrl,
    output logic      [TTB_W-1:0] o_page_table_base,
    output logic      [DW-1:0]    o_domain_permissions,
    output logic                  o_translation_flush_all,
    output logic                  o_translation_purge_entry,
    output logic      [DW-1:0]    o_translation_purge_entry_addr,
    input  wire logic             i_fault_valid,
    input  wire logic             i_fault_data,
    input  wire logic [3:0]       i_fault_domain,
    input  wire logic [3:0]       i_fault_status,
    input  wire logic [DW-1:0]    i_fault_addr,
    input  wire logic             i_req_valid,
    input  wire logic             i_req_write,
    input  wire logic             i_req_cacheable,
    input  wire logic             i_req_updateable,
    input  wire logic [DW-1:0]    i_req_addr,
    input  wire logic [DW-1:0]    i_req_wdata,
    output logic                  o_req_ready,
    output logic                  o_rsp_valid,
    output logic      [DW-1:0]    o_rsp_rdata,
    output logic                  o_ext_valid,
    output logic                  o_ext_write,
    output logic      [DW-1:0]    o_ext_addr,
    output logic      [DW-1:0]    o_ext_wdata,
    input  wire logic             i_ext_ack,
    input  wire logic [DW-1:0]    i_ext_rdata
);
    typedef struct packed {
        uc_state_e                      st;
        uc_ctrl_s                       ctrl;
        logic [TTB_W-1:0]               ttb;
        logic [DW-1:0]                  dac;
        uc_fsr_s                        fsr;
        logic [DW-1:0]                  far;
        logic                           translation_flush_all;
        logic                           translation_purge_entry;
        logic [DW-1:0]                  purge_addr;
        logic                           cp_done;
        logic                           cp_undef;
        logic [DW-1:0]                  cp_rdata;
        uc_req_s                        req;
        logic                           ready;
        logic                           rsp_valid;
        logic [DW-1:0]                  rsp_rdata;
        logic                           ext_valid;
        logic                           ext_write;
        logic [DW-1:0]                  ext_addr;
        logic [DW-1:0]                  ext_wdata;
        logic [WORD_W-1:0]              fill_word;
        logic [WAY_W-1:0]               victim;
        logic [7:0]                     lfsr;
        logic [LINES-1:0][TAG_W-1:0]    tag;
        logic [LINES-1:0]               valid;
    } uc_st_s;

    logic [1:0]        rst_q;
    logic              rst_n;
    uc_st_s            s_q;
    uc_st_s            s_d;
    logic              mem_we;
    logic [MEM_AW-1:0] mem_addr;
    logic [DW-1:0]     mem_wdata;
    logic [DW-1:0]     mem_rdata;
    logic [DW-1:0]     la;
    logic [SET_W-1:0]  set;
    logic [LINE_W-1:0] ln;
    logic              hit;
    logic [WAY_W-1:0]  hway;
    logic              flush;
    logic              cp_ok;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    uc_line_mem #(
        .AW (MEM_AW),
        .W  (DW)
    ) u_mem (
        .i_sys_clk (i_sys_clk),
        .i_we      (mem_we),
        .i_addr    (mem_addr),
        .i_wdata   (mem_wdata),
        .o_rdata   (mem_rdata)
    );

    always_comb begin
        s_d       = s_q;
        mem_we    = 1'b0;
        mem_addr  = '0;
        mem_wdata = '0;
        hit       = 1'b0;
        hway      = '0;
        ln        = '0;
        flush     = 1'b0;
        s_d.translation_flush_all = 1'b0;
        s_d.translation_purge_entry = 1'b0;
        s_d.cp_done   = 1'b0;
        s_d.cp_undef  = 1'b0;
        s_d.rsp_valid = 1'b0;
        // Advances every cycle for victim choice
        s_d.lfsr = {s_q.lfsr[6:0], ^(s_q.lfsr & LFSR_TAPS)};

        // Prefetch faults leave both registers alone
        if (i_fault_valid && i_fault_data) begin
            s_d.fsr = {i_fault_domain, i_fault_status};
            s_d.far = i_fault_addr;
        end

        cp_ok = i_cp_priv && (i_cp_reg < CP_UNDEF);
        if (i_cp_valid) begin
            s_d.cp_done  = 1'b1;
            s_d.cp_rdata = '0;
            if (!cp_ok) begin
                s_d.cp_undef = 1'b1;
            end else if (i_cp_write) begin
                case (i_cp_reg)
                    CP_CTRL: begin
                        s_d.ctrl = uc_ctrl_s'(i_cp_wdata[CTL_W-1:0]);
                    end
                    CP_TTB: begin
                        s_d.ttb = i_cp_wdata[DW-1:TTB_LSB];
                    end
                    CP_DAC: begin
                        s_d.dac = i_cp_wdata;
                    end
                    CP_FSR: begin
                        s_d.translation_flush_all = 1'b1;
                    end
                    CP_FAR: begin
                        s_d.translation_purge_entry  = 1'b1;
                        s_d.purge_addr = i_cp_wdata;
                    end
                    CP_CFL: begin
                        flush = 1'b1;
                    end
                    default: begin
                        // Slot four and the rest do nothing
                    end
                endcase
            end else begin
                case (i_cp_reg)
                    CP_ID: begin
                        s_d.cp_rdata = ID_CODE;
                    end
                    CP_FSR: begin
                        // Bits 11:8 and above return zero
                        s_d.cp_rdata = DW'(s_q.fsr);
                    end
                    CP_FAR: begin
                        s_d.cp_rdata = s_q.far;
                    end
                    default: begin
                        s_d.cp_rdata = '0;
                    end
                endcase
            end
        end

        // Lookup uses the virtual address of the core
        la  = (s_q.st == ST_IDLE) ? i_req_addr : s_q.req.addr;
        set = la[OFS_W +: SET_W];
        for (int w = 0; w < WAYS; w++) begin
            ln = {WAY_W'(w), set};
            if (s_q.valid[ln] && s_q.tag[ln] == la[DW-1:TAG_LSB]) begin
                hit  = 1'b1;
                hway = WAY_W'(w);
            end
        end

        case (s_q.st)
            ST_IDLE: begin
                if (i_req_valid && s_q.ready) begin
                    s_d.ready = 1'b0;
                    s_d.req   = {i_req_write, i_req_cacheable,
                                 i_req_updateable, i_req_addr,
                                 i_req_wdata};
                    s_d.ext_addr  = i_req_addr;
                    s_d.ext_wdata = i_req_wdata;
                    if (i_req_write) begin
                        s_d.ext_valid = 1'b1;
                        s_d.ext_write = 1'b1;
                        s_d.st        = ST_WR;
                        // Update goes on even with the cache off
                        if (i_req_updateable && hit) begin
                            mem_we    = 1'b1;
                            mem_addr  = {hway, set, la[3:2]};
                            mem_wdata = i_req_wdata;
                        end
                    end else if (s_q.ctrl.cache_en &&
                                 i_req_cacheable) begin
                        if (hit) begin
                            mem_addr = {hway, set, la[3:2]};
                            s_d.st   = ST_HIT;
                        end else begin
                            s_d.victim    = s_q.lfsr[WAY_W-1:0];
                            s_d.fill_word = '0;
                            s_d.ext_valid = 1'b1;
                            s_d.ext_write = 1'b0;
                            s_d.ext_addr  = {la[DW-1:OFS_W], LINE_OFS0};
                            s_d.valid[{s_q.lfsr[WAY_W-1:0], set}] = 1'b0;
                            s_d.st        = ST_FILL;
                        end
                    end else begin
                        s_d.ext_valid = 1'b1;
                        s_d.ext_write = 1'b0;
                        s_d.st        = ST_UNC;
                    end
                end
            end
            ST_HIT: begin
                s_d.rsp_valid = 1'b1;
                s_d.rsp_rdata = mem_rdata;
                s_d.ready     = 1'b1;
                s_d.st        = ST_IDLE;
            end
            ST_UNC: begin
                if (i_ext_ack) begin
                    s_d.ext_valid = 1'b0;
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_rdata = i_ext_rdata;
                    s_d.ready     = 1'b1;
                    s_d.st        = ST_IDLE;
                end
            end
            ST_WR: begin
                if (i_ext_ack) begin
                    s_d.ext_valid = 1'b0;
                    s_d.ext_write = 1'b0;
                    s_d.rsp_valid = 1'b1;
                    s_d.ready     = 1'b1;
                    s_d.st        = ST_IDLE;
                end
            end
            ST_FILL: begin
                if (i_ext_ack) begin
                    mem_we    = 1'b1;
                    mem_addr  = {s_q.victim, set, s_q.fill_word};
                    mem_wdata = i_ext_rdata;
                    if (s_q.fill_word == s_q.req.addr[3:2]) begin
                        s_d.rsp_rdata = i_ext_rdata;
                    end
                    if (s_q.fill_word == LAST_WORD) begin
                        s_d.ext_valid = 1'b0;
                        s_d.tag[{s_q.victim, set}] =
                            s_q.req.addr[DW-1:TAG_LSB];
                        s_d.valid[{s_q.victim, set}] = 1'b1;
                        s_d.rsp_valid = 1'b1;
                        s_d.ready     = 1'b1;
                        s_d.st        = ST_IDLE;
                    end else begin
                        s_d.fill_word = s_q.fill_word + 2'h1;
                        s_d.ext_addr[3:2] = s_q.fill_word + 2'h1;
                    end
                end
            end
            default: begin
                s_d.st    = ST_IDLE;
                s_d.ready = 1'b1;
            end
        endcase

        // Flush wins over a fill completing in the same cycle
        if (flush) begin
            s_d.valid = '0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q       <= '0;
            s_q.st    <= ST_IDLE;
            s_q.ready <= 1'b1;
            s_q.lfsr  <= LFSR_SEED;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_cp_done            = s_q.cp_done;
    assign o_cp_undef           = s_q.cp_undef;
    assign o_cp_rdata           = s_q.cp_rdata;
    assign o_ctrl               = s_q.ctrl;
    assign o_page_table_base    = s_q.ttb;
    assign o_domain_permissions = s_q.dac;
    assign o_translation_flush_all          = s_q.translation_flush_all;
    assign o_translation_purge_entry          = s_q.translation_purge_entry;
    assign o_translation_purge_entry_addr     = s_q.purge_addr;
    assign o_req_ready          = s_q.ready;
    assign o_rsp_valid          = s_q.rsp_valid;
    assign o_rsp_rdata          = s_q.rsp_rdata;
    assign o_ext_valid          = s_q.ext_valid;
    assign o_ext_write          = s_q.ext_write;
    assign o_ext_addr           = s_q.ext_addr;
    assign o_ext_wdata          = s_q.ext_wdata;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_cp_wr(logic [3:0] r);
        i_cp_valid && i_cp_write && i_cp_priv && i_cp_reg == r;
    endsequence

    sequence s_acc_rd;
        i_req_valid && o_req_ready && !i_req_write;
    endsequence

    property p_ctrl_wr;
        s_cp_wr(CP_CTRL) |=>
            o_ctrl == uc_ctrl_s'($past(i_cp_wdata[CTL_W-1:0]));
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr)
        else $error("control bits not stored");

    property p_ttb_wr;
        s_cp_wr(CP_TTB) |=>
            o_page_table_base == $past(i_cp_wdata[DW-1:TTB_LSB]);
    endproperty
    a_ttb_wr: assert property (p_ttb_wr)
        else $error("table base not stored");

    property p_dac_wr;
        s_cp_wr(CP_DAC) |=> o_domain_permissions == $past(i_cp_wdata);
    endproperty
    a_dac_wr: assert property (p_dac_wr)
        else $error("domain access not stored");

    property p_undef;
        i_cp_valid && (!i_cp_priv || i_cp_reg >= CP_UNDEF) |=>
            o_cp_undef && o_cp_done && $stable(o_ctrl);
    endproperty
    a_undef: assert property (p_undef)
        else $error("undefined trap missing");

    property p_translation_flush_all;
        s_cp_wr(CP_FSR) |=> o_translation_flush_all ##1
            (!o_translation_flush_all || $past(i_cp_valid && i_cp_write &&
                                   i_cp_priv && i_cp_reg == CP_FSR));
    endproperty
    a_translation_flush_all: assert property (p_translation_flush_all)
        else $error("translation_flush_all pulse wrong");

    property p_purge;
        s_cp_wr(CP_FAR) |=>
            o_translation_purge_entry && o_translation_purge_entry_addr == $past(i_cp_wdata);
    endproperty
    a_purge: assert property (p_purge)
        else $error("translation_purge_entry wrong");

    property p_fsr_rd;
        i_fault_valid && i_fault_data ##1
            (i_cp_valid && !i_cp_write && i_cp_priv &&
             i_cp_reg == CP_FSR && !i_fault_valid) |=>
            o_cp_rdata == DW'({$past(i_fault_domain, 2),
                               $past(i_fault_status, 2)});
    endproperty
    a_fsr_rd: assert property (p_fsr_rd)
        else $error("fault status readback wrong");

    property p_cache_flush;
        s_cp_wr(CP_CFL) |=> s_q.valid == '0;
    endproperty
    a_cache_flush: assert property (p_cache_flush)
        else $error("lines survive flush");

    property p_uncached;
        s_acc_rd ##0 (!i_req_cacheable || !o_ctrl.cache_en) |=>
            o_ext_valid && !o_ext_write && s_q.valid == $past(s_q.valid)
            && s_q.st == ST_UNC;
    endproperty
    a_uncached: assert property (p_uncached)
        else $error("uncached read touched cache");

    property p_nonupd;
        i_req_valid && o_req_ready && i_req_write && !i_req_updateable
            |-> !mem_we ##1 (o_ext_valid && o_ext_write);
    endproperty
    a_nonupd: assert property (p_nonupd)
        else $error("non-updateable write hit cache");

    property p_hit;
        s_acc_rd ##0 (i_req_cacheable && o_ctrl.cache_en && hit) |=>
            !o_ext_valid ##1 o_rsp_valid;
    endproperty
    a_hit: assert property (p_hit)
        else $error("hit not served from cache");
endmodule : uc_top

// *** shared/uc_pkg.sv ***
package uc_pkg;
    localparam int DW      = 32;
    localparam int WAYS    = 64;
    localparam int SET_W   = 2;
    localparam int WAY_W   = 6;
    localparam int WORD_W  = 2;
    localparam int LINE_W  = WAY_W + SET_W;
    localparam int LINES   = 256;
    localparam int MEM_AW  = LINE_W + WORD_W;
    localparam int OFS_W   = 4;
    localparam int TAG_LSB = SET_W + OFS_W;
    localparam int TAG_W   = DW - TAG_LSB;
    localparam int CTL_W   = 9;
    localparam int TTB_LSB = 14;
    localparam int TTB_W   = DW - TTB_LSB;
    localparam int FSR_W   = 8;

    localparam logic [3:0] CP_ID    = 4'h0;
    localparam logic [3:0] CP_CTRL  = 4'h1;
    localparam logic [3:0] CP_TTB   = 4'h2;
    localparam logic [3:0] CP_DAC   = 4'h3;
    localparam logic [3:0] CP_RSV4  = 4'h4;
    localparam logic [3:0] CP_FSR   = 4'h5;
    localparam logic [3:0] CP_FAR   = 4'h6;
    localparam logic [3:0] CP_CFL   = 4'h7;
    localparam logic [3:0] CP_UNDEF = 4'h8;

    localparam logic [WORD_W-1:0] LAST_WORD = 2'h3;
    localparam logic [OFS_W-1:0]  LINE_OFS0 = 4'h0;
    localparam logic [7:0]        LFSR_SEED = 8'h01;
    localparam logic [7:0]        LFSR_TAPS = 8'hb8;

    // Field order puts the MMU enable at bit 0
    typedef struct packed {
        logic system;
        logic big_endian;
        logic late_abort;
        logic data32;
        logic prog32;
        logic wbuf_en;
        logic cache_en;
        logic align_chk;
        logic mmu_en;
    } uc_ctrl_s;

    typedef struct packed {
        logic [3:0] domain;
        logic [3:0] status;
    } uc_fsr_s;

    typedef struct packed {
        logic          write;
        logic          cacheable;
        logic          updateable;
        logic [DW-1:0] addr;
        logic [DW-1:0] wdata;
    } uc_req_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HIT  = 5'b00010,
        ST_UNC  = 5'b00100,
        ST_FILL = 5'b01000,
        ST_WR   = 5'b10000
    } uc_state_e;
endpackage : uc_pkg

// *** verilog/uc_line_mem.sv ***
`timescale 1ns/1ps
module uc_line_mem
    import uc_pkg::*;
#(
    parameter int AW = MEM_AW,
    parameter int W  = DW
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [W-1:0]  i_wdata,
    output logic      [W-1:0]  o_rdata
);
    logic [W-1:0] mem_q [2**AW];
    logic [W-1:0] rdata_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem_q[i_addr] <= i_wdata;
        end
        rdata_q <= mem_q[i_addr];
    end

    assign o_rdata = rdata_q;
endmodule : uc_line_mem

// *** dv/uc_mem_model.sv ***
`timescale 1ns/1ps
module uc_mem_model
    import uc_pkg::*;
(
    input  wire logic          i_sys_clk,
    input  wire logic          i_valid,
    input  wire logic          i_write,
    input  wire logic [DW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic [1:0]    i_delay,
    output logic               o_ack,
    output logic      [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [logic [DW-1:0]];
    logic [1:0]    cnt;

    initial begin
        o_ack   = 1'b0;
        o_rdata = '0;
        cnt     = 2'h0;
    end

    // One ack per word; data bus toggles outside the ack cycle
    always @(posedge i_sys_clk) begin
        o_ack   <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_valid && !o_ack) begin
            if (cnt == i_delay) begin
                cnt   <= 2'h0;
                o_ack <= 1'b1;
                if (i_write)
                    mem[i_addr] = i_wdata;
                else if (mem.exists(i_addr))
                    o_rdata <= mem[i_addr];
                else
                    o_rdata <= {i_addr[15:0], ~i_addr[15:0]};
            end else begin
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule : uc_mem_model

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench
    import uc_pkg::*;
;
    `define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
        $display("ERROR %0t mismatch %h %h", $time, a, b); end end

    logic          clk, rstn, cpv, cpw, cpp, fv, fd, rv, rw, rc, ru;
    logic [3:0]    cpr, fdom, fst;
    logic [DW-1:0] cpwd, fa, ra, rwd, ext_rd, ext_a, ext_wd, rd, wd, wd2, a;
    logic          cdone, cundef, tfl, tpu, rsp, rdy, ev, ew, ack, und;
    logic          fl, pu;
    logic [DW-1:0] crd, tpa, dac, rrd;
    logic [TTB_W-1:0] ttb;
    uc_ctrl_s      ctl;
    logic [1:0]    dly;
    int            num_errors, checks, acks, n, na, i, seed;

    uc_top u_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_cp_valid(cpv),
        .i_cp_write(cpw), .i_cp_priv(cpp), .i_cp_reg(cpr), .i_cp_wdata(cpwd),
        .o_cp_done(cdone), .o_cp_undef(cundef), .o_cp_rdata(crd),
        .o_ctrl(ctl), .o_page_table_base(ttb), .o_domain_permissions(dac),
        .o_translation_flush_all(tfl), .o_translation_purge_entry(tpu), .o_translation_purge_entry_addr(tpa),
        .i_fault_valid(fv), .i_fault_data(fd), .i_fault_domain(fdom),
        .i_fault_status(fst), .i_fault_addr(fa), .i_req_valid(rv),
        .i_req_write(rw), .i_req_cacheable(rc), .i_req_updateable(ru),
        .i_req_addr(ra), .i_req_wdata(rwd), .o_req_ready(rdy),
        .o_rsp_valid(rsp), .o_rsp_rdata(rrd), .o_ext_valid(ev),
        .o_ext_write(ew), .o_ext_addr(ext_a), .o_ext_wdata(ext_wd),
        .i_ext_ack(ack), .i_ext_rdata(ext_rd));

    uc_mem_model u_mem (.i_sys_clk(clk), .i_valid(ev), .i_write(ew),
        .i_addr(ext_a), .i_wdata(ext_wd), .i_delay(dly), .o_ack(ack),
        .o_rdata(ext_rd));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) if (ack === 1'b1) acks <= acks + 1;

    function automatic logic [DW-1:0] exp_mem(input logic [DW-1:0] ad);
        return {ad[15:0], ~ad[15:0]};
    endfunction : exp_mem

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic cp(input logic w, p, input logic [3:0] r,
                      input logic [DW-1:0] d);
        @(posedge clk);
        cpv <= 1'b1; cpw <= w; cpp <= p; cpr <= r; cpwd <= d;
        @(posedge clk);
        cpv <= 1'b0;
        #1;
        `CHK(cdone, 1'b1);
        und = cundef; rd = crd; fl = tfl; pu = tpu;
    endtask : cp

    task automatic acc(input logic w, c, u, input logic [DW-1:0] ad, d);
        int a0;
        @(posedge clk);
        rv <= 1'b1; rw <= w; rc <= c; ru <= u; ra <= ad; rwd <= d;
        dly <= 2'($random(seed));
        a0 = acks;
        @(posedge clk);
        rv <= 1'b0;
        n = 1;
        #1;
        while (rsp !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 300) begin
            num_errors++;
            report_and_stop();
        end
        rd = rrd; na = acks - a0;
    endtask : acc

    initial begin
        seed = 32'h8ab0;
        {rstn, cpv, cpw, cpp, fv, fd, rv, rw, rc, ru} = '0;
        {cpr, fdom, fst, cpwd, fa, ra, rwd, dly} = '0;
        num_errors = 0; checks = 0; acks = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK(ctl, 9'h000);
        for (i = 2; i <= 8; i++) begin
            wd = 32'h1 << i;
            cp(1'b1, 1'b1, CP_CTRL, wd);
            `CHK(ctl, wd[8:0]);
        end
        wd = $random(seed);
        cp(1'b1, 1'b1, CP_CTRL, wd);
        `CHK(ctl, wd[8:0]);
        cp(1'b1, 1'b1, CP_TTB, wd);
        `CHK(ttb, wd[31:14]);
        wd2 = $random(seed);
        cp(1'b1, 1'b1, CP_DAC, wd2);
        `CHK(dac, wd2);
        cp(1'b1, 1'b1, CP_RSV4, ~wd);
        `CHK({und, ttb, ctl}, {1'b0, wd[31:14], wd[8:0]});
        cp(1'b0, 1'b1, CP_RSV4, 32'h0);
        `CHK(rd, 32'h0);
        for (i = 8; i <= 15; i++) begin
            cp(1'b1, 1'b1, 4'(i), 32'h0);
            `CHK(und, 1'b1);
        end
        cp(1'b1, 1'b0, CP_CTRL, ~wd);
        `CHK({und, ctl}, {1'b1, wd[8:0]});
        $display("test registers done");
        a = $random(seed);
        @(posedge clk);
        fv <= 1'b1; fd <= 1'b1; fdom <= a[7:4]; fst <= a[3:0]; fa <= wd;
        @(posedge clk);
        fd <= 1'b0; fdom <= ~a[7:4]; fst <= ~a[3:0]; fa <= ~wd;
        @(posedge clk);
        fv <= 1'b0;
        cp(1'b0, 1'b1, CP_FSR, 32'h0);
        `CHK(rd, {24'h0, a[7:0]});
        cp(1'b0, 1'b1, CP_FAR, 32'h0);
        `CHK(rd, wd);
        // Data fault followed at once by a status read
        @(posedge clk);
        fv <= 1'b1; fd <= 1'b1; fdom <= ~a[7:4]; fst <= ~a[3:0];
        fork
            cp(1'b0, 1'b1, CP_FSR, 32'h0);
            @(posedge clk) fv <= 1'b0;
        join
        `CHK(rd, {24'h0, ~a[7:0]});
        cp(1'b1, 1'b1, CP_FSR, wd2);
        `CHK({fl, pu}, 2'b10);
        cp(1'b1, 1'b1, CP_FAR, wd2);
        `CHK({fl, pu, tpa}, {2'b01, wd2});
        $display("test faults done");
        cp(1'b1, 1'b1, CP_CTRL, 32'h5);
        a = {$random(seed)} & 32'h000f_fff0;
        acc(1'b0, 1'b1, 1'b0, a, 32'h0);
        `CHK({na, rd}, {32'd4, exp_mem(a)});
        acc(1'b0, 1'b1, 1'b0, a, 32'h0);
        `CHK({n, na, rd}, {32'd2, 32'd0, exp_mem(a)});
        acc(1'b0, 1'b1, 1'b0, a + 32'hc, 32'h0);
        `CHK({na, rd}, {32'd0, exp_mem(a + 32'hc)});
        // Next set over, so its fill can never evict the line of a
        acc(1'b0, 1'b0, 1'b0, a + 32'h110, 32'h0);
        `CHK({na, rd}, {32'd1, exp_mem(a + 32'h110)});
        acc(1'b0, 1'b1, 1'b0, a + 32'h110, 32'h0);
        `CHK(na, 4);
        acc(1'b1, 1'b0, 1'b1, a, wd);
        `CHK(na, 1);
        acc(1'b0, 1'b1, 1'b0, a, 32'h0);
        `CHK({na, rd}, {32'd0, wd});
        acc(1'b1, 1'b0, 1'b0, a, wd2);
        acc(1'b0, 1'b1, 1'b0, a, 32'h0);
        `CHK({na, rd}, {32'd0, wd});
        cp(1'b1, 1'b1, CP_CFL, 32'h0);
        acc(1'b0, 1'b1, 1'b0, a, 32'h0);
        `CHK({na, rd}, {32'd4, wd2});
        cp(1'b1, 1'b1, CP_CTRL, 32'h1);
        acc(1'b0, 1'b1, 1'b0, a, 32'h0);
        `CHK(na, 1);
        cp(1'b1, 1'b1, CP_CTRL, 32'h5);
        for (i = 0; i < 24; i++) begin
            a = 32'h0100_0000 | ({$random(seed)} & 32'h0000_00fc);
            acc(1'b0, 1'b1, 1'b0, a, 32'h0);
            `CHK({rd, na == 0 || na == 4}, {exp_mem(a), 1'b1});
        end
        $display("test cache done");
        // Reset in mid-run drops the enable and every valid line
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK({ctl, rdy}, {9'h000, 1'b1});
        cp(1'b1, 1'b1, CP_CTRL, 32'h5);
        acc(1'b0, 1'b1, 1'b0, a, 32'h0);
        `CHK({na, rd}, {32'd4, exp_mem(a)});
        $display("test reset done");
        report_and_stop();
    end
endmodule : testbench
